// file: analog_side_model.sv
// behavioural model of the timing node and output comparators
`timescale 1ns/1ps
module analog_side_model
(
    // clock
    input  wire logic       clk,
    // controls from the sequencer
    input  wire logic       node_discharge,
    input  wire logic       node_charge_first,
    input  wire logic       node_charge_second,
    input  wire logic       drive_high,
    // charge times of the two sources, in cycles
    input  wire logic [7:0] first_cyc,
    input  wire logic [7:0] second_cyc,
    // comparator outputs
    output logic            node_above_7v,
    output logic            node_at_plateau,
    output logic            out_below_plateau
);
    logic [9:0] chg_ff = '0;
    logic [2:0] fall_ff = '0;

    always @(posedge clk)
    begin
        if (node_discharge)
            chg_ff <= '0;
        else if ((node_charge_first || node_charge_second) && chg_ff != '1)
            chg_ff <= chg_ff + 10'h001;
        if (drive_high)
            fall_ff <= '0;
        else if (fall_ff != 3'h3)
            fall_ff <= fall_ff + 3'h1;
    end

    // only the second source lifts the node up to the plateau level
    assign node_above_7v = chg_ff >= {2'h0, first_cyc};
    assign node_at_plateau = node_charge_second
        && chg_ff >= {2'h0, first_cyc} + {2'h0, second_cyc};
    assign out_below_plateau = fall_ff == 3'h3;
endmodule : analog_side_model

// file: test_two_level_turnoff_sequencer.sv
// self-checking bench for the two-level turn-off sequencer
`timescale 1ns/1ps
module test_two_level_turnoff_sequencer;
    logic clk, rst, cmd_on, shutdown_n, sense_trip, sense_blank_done;
    logic sense_delay_done, node_above_7v, node_at_plateau, hi_prev;
    logic out_below_plateau, node_discharge, node_charge_first;
    logic node_charge_second, sense_blank_release, drive_high;
    logic drive_plateau, fault_flag_output, fault_flag_output_oe;
    logic [7:0] first_cyc, second_cyc;
    int n_mismatch, check_count, cyc_n, t_dis, t_on, hold, w_dis, w_plat;
    int n, len;
    int q_dis[$];
    int q_plat[$];

    two_level_turnoff_sequencer dut (.clk(clk), .rst(rst), .cmd_on(cmd_on),
        .shutdown_n(shutdown_n), .node_above_7v(node_above_7v),
        .node_at_plateau(node_at_plateau),
        .out_below_plateau(out_below_plateau), .sense_trip(sense_trip),
        .sense_blank_done(sense_blank_done),
        .sense_delay_done(sense_delay_done),
        .node_discharge(node_discharge),
        .node_charge_first(node_charge_first),
        .node_charge_second(node_charge_second),
        .sense_blank_release(sense_blank_release),
        .drive_high(drive_high), .drive_plateau(drive_plateau),
        .fault_flag_output(fault_flag_output),
        .fault_flag_output_oe(fault_flag_output_oe));

    analog_side_model far_side (.clk(clk), .node_discharge(node_discharge),
        .node_charge_first(node_charge_first),
        .node_charge_second(node_charge_second), .drive_high(drive_high),
        .first_cyc(first_cyc), .second_cyc(second_cyc),
        .node_above_7v(node_above_7v), .node_at_plateau(node_at_plateau),
        .out_below_plateau(out_below_plateau));

    // =======================================================
    // compare and helper tasks
    task automatic check_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : check_bit

    task automatic check_int(input string nm, input int e, input int g);
        check_count++;
        if (g != e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : check_int

    // a pulse that appears takes the oldest note of its kind
    task automatic pulse_done(input bit plat, input int w);
        int e;
        e = -1;
        if (plat && q_plat.size() > 0)
            e = q_plat.pop_front();
        if (!plat && q_dis.size() > 0)
            e = q_dis.pop_front();
        check_int(plat ? "plateau cycles" : "discharge cycles", e, w);
    endtask : pulse_done

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic wait_for(input bit plat, input logic v, output int k);
        k = 0;
        while ((plat ? drive_plateau : drive_high) !== v && k < 2000)
        begin
            @(posedge clk);
            #1 k++;
        end
        if (k == 2000)
            check_int("wait cycles", 0, k);
    endtask : wait_for

    task automatic turn_on;
        q_dis.push_back(100);
        @(posedge clk);
        first_cyc <= 8'(20 + $urandom % 40);
        second_cyc <= 8'(10 + $urandom % 20);
        cmd_on <= 1'b1;
        wait_for(1'b0, 1'b1, n);
        cyc(1);
        #1;
        hold = t_on - t_dis - 41;
        if (hold < 1)
            hold = 1;
        check_bit("blank release", 1'b1, sense_blank_release);
    endtask : turn_on

    task automatic pulse_shutdown(input int k);
        @(posedge clk);
        shutdown_n <= 1'b0;
        cyc(k);
        shutdown_n <= 1'b1;
        cyc(12);
        #1;
    endtask : pulse_shutdown

    task stop_test;
        check_int("plateau notes left", 0, q_plat.size());
        check_int("discharge notes left", 0, q_dis.size());
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // =======================================================
    // clock, watchdog and output monitor
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end

    always @(posedge clk)
    begin
        cyc_n++;
        if (node_discharge === 1'b1 && w_dis == 0)
            t_dis = cyc_n;
        if (drive_high === 1'b1 && hi_prev !== 1'b1)
            t_on = cyc_n;
        hi_prev = drive_high;
        if (node_charge_second === 1'b1)
        begin
            check_bit("above 7v", 1'b1, node_above_7v);
            check_bit("first off", 1'b0, node_charge_first);
        end
        if (node_discharge === 1'b1)
            w_dis++;
        else if (w_dis != 0)
        begin
            pulse_done(1'b0, w_dis);
            w_dis = 0;
        end
        if (drive_plateau === 1'b1)
            w_plat++;
        else if (w_plat != 0)
        begin
            pulse_done(1'b1, w_plat);
            w_plat = 0;
        end
    end

    // =======================================================
    // scenarios
    initial
    begin
        void'($urandom(32'h0000_09b1));
        rst = 1'b1;
        cmd_on = 1'b0;
        shutdown_n = 1'b1;
        sense_trip = 1'b0;
        sense_blank_done = 1'b0;
        sense_delay_done = 1'b0;
        first_cyc = 8'h14;
        second_cyc = 8'h0a;
        cyc(3);
        rst <= 1'b0;
        cyc(8);
        #1 check_bit("fault idle", 1'b0, fault_flag_output_oe);
        turn_on();
        len = 1 + $urandom % hold;
        @(posedge clk);
        cmd_on <= 1'b0;
        cyc(len);
        cmd_on <= 1'b1;
        cyc(hold + 60);
        #1 check_bit("short off", 1'b1, drive_high);
        q_plat.push_back(hold);
        @(posedge clk);
        cmd_on <= 1'b0;
        wait_for(1'b1, 1'b1, n);
        @(posedge clk);
        cmd_on <= 1'b1;
        wait_for(1'b1, 1'b0, n);
        check_bit("re-on", 1'b1, drive_high);
        q_plat.push_back(hold);
        @(posedge clk);
        cmd_on <= 1'b0;
        wait_for(1'b0, 1'b0, n);
        check_bit("off delay", 1'b1, n >= hold + 40 && n <= hold + 43);
        wait_for(1'b1, 1'b1, n);
        wait_for(1'b1, 1'b0, n);
        repeat (3)
        begin
            len = 1 + $urandom % hold;
            @(posedge clk);
            cmd_on <= 1'b1;
            cyc(len);
            cmd_on <= 1'b0;
            cyc(hold + 20);
            #1 check_bit("short on", 1'b0, drive_high);
        end
        turn_on();
        @(posedge clk);
        sense_blank_done <= 1'b1;
        sense_trip <= 1'b1;
        cyc(2);
        #1 check_bit("fault set", 1'b1, fault_flag_output_oe);
        check_bit("fault level", 1'b0, fault_flag_output);
        q_plat.push_back(hold);
        @(posedge clk);
        sense_delay_done <= 1'b1;
        wait_for(1'b0, 1'b0, n);
        check_bit("desaturation_sense off", 1'b1, n <= 3);
        wait_for(1'b1, 1'b1, n);
        wait_for(1'b1, 1'b0, n);
        cyc(200);
        #1 check_bit("inputs ignored", 1'b0, drive_high);
        @(posedge clk);
        cmd_on <= 1'b0;
        sense_trip <= 1'b0;
        sense_delay_done <= 1'b0;
        pulse_shutdown(50);
        check_bit("fault kept", 1'b1, fault_flag_output_oe);
        pulse_shutdown(200);
        check_bit("fault cleared", 1'b0, fault_flag_output_oe);
        turn_on();
        pulse_shutdown(3);
        check_bit("glitch", 1'b1, drive_high);
        q_plat.push_back(hold);
        @(posedge clk);
        shutdown_n <= 1'b0;
        cyc(hold + 80);
        #1 check_bit("shutdown off", 1'b0, drive_high);
        stop_test();
    end
endmodule : test_two_level_turnoff_sequencer

// file: turnoff_pkg.sv
// types for the two-level turn-off sequencer
`include "turnoff_regs.svh"
package turnoff_pkg;

    typedef enum logic [6:0] {
        ST_OFF       = 7'b000_0001,
        ST_QUAL_ON   = 7'b000_0010,
        ST_DISCHARGE = 7'b000_0100,
        ST_CHARGE    = 7'b000_1000,
        ST_ON        = 7'b001_0000,
        ST_FALL      = 7'b010_0000,
        ST_PLATEAU   = 7'b100_0000
    } seq_state_t;

    typedef struct packed {
        seq_state_t              state;
        logic [`CNT_W-1:0]       cnt;
        logic [`CNT_W-1:0]       hold;
        logic [`CNT_W-1:0]       meas;
        logic [`CNT_W-1:0]       offc;
        logic [`CNT_W-1:0]       dly;
        logic [`CNT_W-1:0]       low_cnt;
        logic [`SHD_W-1:0]       shd_cnt;
        logic [2:0]              shd_sync;
        logic                    shd_prev;
        logic                    shd_low;
        logic                    fault;
        logic                    desaturation_sense_lock;
        logic                    drive_high;
        logic                    drive_plateau;
        logic                    discharge;
        logic                    charge_first;
        logic                    charge_second;
        logic                    blank_release;
    } seq_regs_t;

endpackage : turnoff_pkg

// file: turnoff_regs.svh
// timing constants and figures for the two-level turn-off sequencer
`ifndef TURNOFF_REGS_SVH
`define TURNOFF_REGS_SVH

`define CLK_PERIOD_PS        5000
`define DISCHARGE_TIME_NS    500
`define DISCHARGE_CYC        ((`DISCHARGE_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define PROP_DELAY_NS        200
`define PROP_DELAY_CYC       ((`PROP_DELAY_NS * 1000) / `CLK_PERIOD_PS)
`define SHUTDOWN_MIN_NS      30
`define SHUTDOWN_MIN_CYC     \
    ((`SHUTDOWN_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FAULT_CLR_MIN_NS     800
`define FAULT_CLR_MIN_CYC    \
    ((`FAULT_CLR_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CNT_W                16
`define CNT_MAX              16'hFFFF
`define CNT_ZERO             16'h0000
`define CNT_ONE              16'h0001
`define SHD_W                8

`endif

// file: two_level_turnoff_sequencer.sv
// two-level turn-off sequencer of an isolated gate driver
`timescale 1ns/1ps
`include "turnoff_regs.svh"

module two_level_turnoff_sequencer
    import turnoff_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // command inputs, already in clk domain
    input  wire logic cmd_on,
    // shutdown pin, active low, asynchronous
    input  wire logic shutdown_n,
    // analog comparators, already in clk domain
    input  wire logic node_above_7v,
    input  wire logic node_at_plateau,
    input  wire logic out_below_plateau,
    input  wire logic sense_trip,
    input  wire logic sense_blank_done,
    input  wire logic sense_delay_done,
    // analog controls
    output logic      node_discharge,
    output logic      node_charge_first,
    output logic      node_charge_second,
    output logic      sense_blank_release,
    output logic      drive_high,
    output logic      drive_plateau,
    // status
    output logic      fault_flag_output,
    output logic      fault_flag_output_oe
);

    seq_regs_t cur_ff;
    seq_regs_t nxt_ff;

    logic shd_level;
    logic shd_rise;
    logic want_on;
    logic desaturation_sense_go;

    // =====================================================================
    // filtered shutdown level and edge, trip release and turn-on qualification
    // =====================================================================
    always_comb
    begin
        shd_level = cur_ff.shd_low;
        shd_rise  = cur_ff.shd_prev & ~cur_ff.shd_low;
        desaturation_sense_go  = cur_ff.desaturation_sense_lock & sense_delay_done;
        want_on   = cmd_on & ~cur_ff.shd_low & ~cur_ff.desaturation_sense_lock
                    & ~cur_ff.fault;
    end

    // =====================================================================
    // sequencer
    // =====================================================================
    always_comb
    begin
        nxt_ff          = cur_ff;
        nxt_ff.shd_sync = {cur_ff.shd_sync[1:0], shutdown_n};
        nxt_ff.shd_prev = cur_ff.shd_low;
        // a level counts once the second and third stages have agreed on it for SHUTDOWN_MIN_CYC cycles
        if (cur_ff.shd_sync[1] == cur_ff.shd_sync[2])
        begin
            if ((~cur_ff.shd_sync[2]) != cur_ff.shd_low)
            begin
                if (cur_ff.shd_cnt >= `SHD_W'(`SHUTDOWN_MIN_CYC - 1))
                begin
                    nxt_ff.shd_low = ~cur_ff.shd_sync[2];
                    nxt_ff.shd_cnt = '0;
                end
                else
                    nxt_ff.shd_cnt = cur_ff.shd_cnt + `SHD_W'(1);
            end
            else
                nxt_ff.shd_cnt = '0;
        end
        else
            nxt_ff.shd_cnt = '0;
        if (shd_level && cur_ff.low_cnt != `CNT_MAX)
            nxt_ff.low_cnt = cur_ff.low_cnt + `CNT_ONE;
        else if (!shd_level && !shd_rise)
            nxt_ff.low_cnt = `CNT_ZERO;
        if (cur_ff.meas != `CNT_MAX)
            nxt_ff.meas = cur_ff.meas + `CNT_ONE;
        nxt_ff.cnt = cur_ff.cnt + `CNT_ONE;

        // desaturation trip during conduction after blanking
        if (cur_ff.state == ST_ON && cur_ff.blank_release && sense_trip
            && sense_blank_done)
        begin
            nxt_ff.desaturation_sense_lock = 1'b1;
            nxt_ff.fault      = 1'b1;
        end
        // set wins over clear on the same cycle
        else if (shd_rise && cur_ff.low_cnt >= `CNT_W'(`FAULT_CLR_MIN_CYC))
        begin
            nxt_ff.fault      = 1'b0;
        end
        if (cur_ff.state == ST_OFF)
            nxt_ff.desaturation_sense_lock = 1'b0;

        unique case (cur_ff.state)
            ST_OFF:
            begin
                nxt_ff.drive_high    = 1'b0;
                nxt_ff.drive_plateau = 1'b0;
                if (want_on)
                begin
                    nxt_ff.state = ST_QUAL_ON;
                    nxt_ff.cnt   = `CNT_ZERO;
                end
            end
            ST_QUAL_ON:
            begin
                if (!want_on)
                    nxt_ff.state = ST_OFF;
                else if (cur_ff.cnt >= cur_ff.hold)
                begin
                    nxt_ff.state     = ST_DISCHARGE;
                    nxt_ff.cnt       = `CNT_ZERO;
                    nxt_ff.meas      = `CNT_ZERO;
                    nxt_ff.discharge = 1'b1;
                end
            end
            ST_DISCHARGE:
            begin
                if (cur_ff.cnt >= `CNT_W'(`DISCHARGE_CYC - 1))
                begin
                    nxt_ff.discharge    = 1'b0;
                    nxt_ff.charge_first = 1'b1;
                    nxt_ff.state        = ST_CHARGE;
                end
            end
            ST_CHARGE:
            begin
                if (node_above_7v)
                begin
                    nxt_ff.charge_first  = 1'b0;
                    nxt_ff.charge_second = 1'b1;
                end
                if (node_above_7v && node_at_plateau)
                begin
                    nxt_ff.charge_second = 1'b0;
                    nxt_ff.drive_high    = 1'b1;
                    nxt_ff.blank_release = 1'b1;
                    nxt_ff.state         = ST_ON;
                    nxt_ff.offc          = `CNT_ZERO;
                    // stored in cycles as the measured time less PROP_DELAY_CYC, at least one
                    nxt_ff.hold = (cur_ff.meas > `CNT_W'(`PROP_DELAY_CYC))
                        ? cur_ff.meas - `CNT_W'(`PROP_DELAY_CYC)
                        : `CNT_ONE;
                end
            end
            ST_ON:
            begin
                if (desaturation_sense_go)
                begin
                    nxt_ff.drive_high = 1'b0;
                    nxt_ff.state      = ST_FALL;
                end
                else if (want_on || cur_ff.desaturation_sense_lock)
                    nxt_ff.offc = `CNT_ZERO;
                else if (cur_ff.offc >= cur_ff.hold
                         + `CNT_W'(`PROP_DELAY_CYC) || cur_ff.shd_low)
                begin
                    nxt_ff.drive_high    = 1'b0;
                    nxt_ff.blank_release = 1'b0;
                    nxt_ff.state         = ST_FALL;
                end
                else
                    nxt_ff.offc = cur_ff.offc + `CNT_ONE;
            end
            ST_FALL:
            begin
                nxt_ff.blank_release = 1'b0;
                if (out_below_plateau)
                begin
                    nxt_ff.drive_plateau = 1'b1;
                    nxt_ff.state         = ST_PLATEAU;
                    nxt_ff.cnt           = `CNT_ZERO;
                end
            end
            ST_PLATEAU:
            begin
                if (cur_ff.cnt + `CNT_ONE >= cur_ff.hold)
                begin
                    nxt_ff.drive_plateau = 1'b0;
                    if (want_on)
                    begin
                        nxt_ff.drive_high    = 1'b1;
                        nxt_ff.blank_release = 1'b1;
                        nxt_ff.offc          = `CNT_ZERO;
                        nxt_ff.state         = ST_ON;
                    end
                    else
                        nxt_ff.state = ST_OFF;
                end
            end
        endcase

        if (rst)
        begin
            nxt_ff           = '0;
            nxt_ff.state     = ST_OFF;
            nxt_ff.hold      = `CNT_ONE;
            nxt_ff.shd_sync  = 3'b111;
        end
    end

    always_ff @(posedge clk)
    begin
        cur_ff <= nxt_ff;
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign node_discharge       = cur_ff.discharge;
    assign node_charge_first    = cur_ff.charge_first;
    assign node_charge_second   = cur_ff.charge_second;
    assign sense_blank_release  = cur_ff.blank_release;
    assign drive_high           = cur_ff.drive_high;
    assign drive_plateau        = cur_ff.drive_plateau;
    assign fault_flag_output    = 1'b0;
    assign fault_flag_output_oe = cur_ff.fault;

    // =====================================================================
    // assertions
    // =====================================================================
    sequence s_plateau_exit;
        drive_plateau ##1 !drive_plateau;
    endsequence

    a_discharge_len: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_ff.discharge) |-> cur_ff.discharge [*8] ##0
        (cur_ff.state == ST_DISCHARGE))
        else $error("discharge phase too short");

    a_on_after_plat: assert property (@(posedge clk) disable iff (rst)
        $rose(drive_high) && $past(cur_ff.state) == ST_CHARGE
        |-> $past(node_at_plateau))
        else $error("output on before plateau reached");

    a_hold_stored: assert property (@(posedge clk) disable iff (rst)
        cur_ff.state == ST_ON && $past(cur_ff.state) == ST_CHARGE
        |-> cur_ff.hold != `CNT_ZERO)
        else $error("hold time not stored");

    a_plateau_nocut: assert property (@(posedge clk) disable iff (rst)
        s_plateau_exit |-> $past(cur_ff.cnt) + `CNT_ONE
        == $past(cur_ff.hold))
        else $error("plateau shortened");

    a_plateau_level: assert property (@(posedge clk) disable iff (rst)
        cur_ff.state == ST_PLATEAU |-> drive_plateau && !drive_high)
        else $error("plateau level not held");

    a_short_on: assert property (@(posedge clk) disable iff (rst)
        cur_ff.state == ST_QUAL_ON && !want_on |=> cur_ff.state == ST_OFF)
        else $error("short on pulse not suppressed");

    a_desaturation_sense_low: assert property (@(posedge clk) disable iff (rst)
        cur_ff.state == ST_ON && desaturation_sense_go |=> !drive_high)
        else $error("desaturation did not drive low");

    a_fault_set: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_ff.desaturation_sense_lock) |-> fault_flag_output_oe)
        else $error("fault flag not raised");

    a_fault_keep: assert property (@(posedge clk) disable iff (rst)
        $fell(cur_ff.fault) |-> $past(cur_ff.low_cnt)
        >= `CNT_W'(`FAULT_CLR_MIN_CYC))
        else $error("fault cleared after short shutdown");

endmodule : two_level_turnoff_sequencer
